// File: dv/lookup_store_model.sv
`timescale 1ns/100ps

module lookup_store_model
(
    input  wire [11:0] index_ptr_i,
    output wire [7:0]  lut_data_o
);
// ----------------------------------------
// byte pattern
// ----------------------------------------
    // byte per pointer
    // all twelve bits mixed in, so a wrong nibble shows
    assign lut_data_o = index_ptr_i[7:0] ^ {index_ptr_i[11:8], index_ptr_i[11:8]};
endmodule // lookup_store_model

// File: dv/nibble_seq_properties.sv
`timescale 1ns/100ps
`include "nibble_seq_consts.vh"

module nibble_seq_checker
#(
    parameter [3:0] SPLIT_N = 4'h0
)
(
    input wire                 sys_clk_i,
    input wire                 srst_i,
    input wire                 step_i,
    input wire [`XFER_W-1:0]   xfer_i,
    input wire [10:0]          operand_i,
    input wire [`OP_W-1:0]     op_i,
    input wire [5:0]           irq_req_i,
    input wire [7:0]           lut_data_i,
    input wire [`PC_W-1:0]     pc_o,
    input wire [`SP_W-1:0]     stack_ptr_o,
    input wire [3:0]           sum_o,
    input wire                 carry_o,
    input wire [7:0]           lut_byte_o,
    input wire                 lut_valid_o,
    input wire                 irq_ack_o,
    input wire [11:0]          code_words_o,
    input wire [11:0]          lut_bytes_o
);
// ----------------------------------------
// helpers
// ----------------------------------------
    // an interrupt step executes no instruction
    wire        go    = step_i && (irq_req_i == 6'h00);
    wire [3:0]  n_eff = (SPLIT_N > `SPLIT_N_MAX) ? `SPLIT_N_MAX : SPLIT_N;
    reg  [10:0] vec_exp;

    always @*
    begin
        casez (irq_req_i)
            6'b?????1: vec_exp = `VEC_EXT_PIN;
            6'b????10: vec_exp = `VEC_PORT_CD;
            6'b???100: vec_exp = `VEC_TIMER1;
            6'b??1000: vec_exp = `VEC_PREDIV;
            6'b?10000: vec_exp = `VEC_TIMER2;
            default:   vec_exp = `VEC_RFC;
        endcase
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
// ----------------------------------------
// properties
// ----------------------------------------
    AST_PC_STEP:
        assert property (go && xfer_i == `XFER_NONE |=> pc_o == $past(pc_o) + 11'h001)
        else $error("pc not advanced");
    AST_LONG_JUMP:
        assert property (go && xfer_i == `XFER_LONG_JUMP |=> pc_o == $past(operand_i))
        else $error("long jump target wrong");
    AST_PAGE_JUMP:
        assert property (go && xfer_i == `XFER_PAGE_JUMP
            |=> pc_o == {$past(pc_o[10]), $past(operand_i[9:0])})
        else $error("page jump target wrong");
    AST_VECTOR:
        assert property (step_i && irq_req_i != 6'h00 |=> irq_ack_o && pc_o == $past(vec_exp)
            && stack_ptr_o == $past(stack_ptr_o) + 3'h1)
        else $error("interrupt entry wrong");
    AST_CALL_PUSH:
        assert property (go && xfer_i == `XFER_CALL |=> pc_o == $past(operand_i)
            && stack_ptr_o == $past(stack_ptr_o) + 3'h1)
        else $error("call wrong");
    AST_RET_POP:
        assert property (go && xfer_i == `XFER_RETURN |=> stack_ptr_o == $past(stack_ptr_o) - 3'h1)
        else $error("return pointer wrong");
    AST_SPLIT:
        assert property (code_words_o == `CODE_BASE_WORDS + `CODE_STEP_WORDS * n_eff
            && lut_bytes_o == `LUT_STEP_BYTES * (`SPLIT_N_MAX - n_eff))
        else $error("rom split wrong");
    AST_LUT:
        assert property (go && op_i == `OP_LUT_RD |=> lut_valid_o && lut_byte_o == $past(lut_data_i))
        else $error("lookup byte wrong");
    AST_DAA_HIGH:
        assert property (go && op_i == `OP_DAA && !carry_o && sum_o > 4'h9
            |=> sum_o == $past(sum_o) + 4'h6 && carry_o)
        else $error("add adjust wrong");
    AST_DAS_HIGH:
        assert property (go && op_i == `OP_DAS && !carry_o && sum_o > 4'h5
            |=> sum_o == $past(sum_o) + 4'ha && !carry_o)
        else $error("sub adjust wrong");
endmodule // nibble_seq_checker

bind nibble_cpu_sequencer_core nibble_seq_checker #(.SPLIT_N(SPLIT_N)) i_chk (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .step_i(step_i), .xfer_i(xfer_i),
    .operand_i(operand_i), .op_i(op_i), .irq_req_i(irq_req_i), .lut_data_i(lut_data_i),
    .pc_o(pc_o), .stack_ptr_o(stack_ptr_o), .sum_o(sum_o), .carry_o(carry_o),
    .lut_byte_o(lut_byte_o), .lut_valid_o(lut_valid_o), .irq_ack_o(irq_ack_o),
    .code_words_o(code_words_o), .lut_bytes_o(lut_bytes_o));

// File: dv/test_nibble_cpu_sequencer_core.sv
`timescale 1ns/100ps
`include "nibble_seq_consts.vh"

module test_nibble_cpu_sequencer_core;
    reg  sys_clk_i;
    reg  srst_i = 1'b1;
    reg  step_i = 1'b0;
    reg  [2:0] xfer_i = 3'h0;
    reg  [2:0] cond_i = 3'h0;
    reg  [10:0] operand_i = 11'h000;
    reg  [4:0] op_i = 5'h00;
    reg  indexed_i = 1'b0;
    reg  [6:0] dir_addr_i = 7'h00;
    reg  [3:0] wr_sel_i = 4'h0;
    reg  [3:0] imm_i = 4'h0;
    reg  [5:0] irq_req_i = 6'h00;
    wire [7:0] lut_data_i;
    wire [10:0] pc_o;
    wire [11:0] index_ptr_o, code_words_o, lut_bytes_o;
    wire [2:0] stack_ptr_o;
    wire [3:0] sum_o, disp_data_o;
    wire [7:0] lut_byte_o;
    wire carry_o, zero_o, lut_valid_o, disp_strobe_o, irq_ack_o;
    integer error_cnt = 0;
    integer total_checks = 0;
    integer cyc = 0;
    integer i;
    logic [10:0] vt [7] = '{11'h010, 11'h014, 11'h018, 11'h01c, 11'h020, 11'h028, 11'h020};
    logic [5:0]  qt [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h30};
    logic [6:0]  at [3] = '{7'h05, 7'h06, 7'h73};
    logic [4:0]  pt [3] = '{`OP_PTR_LOW, `OP_PTR_MID, `OP_PTR_TOP};
    logic [11:0] it [3] = '{12'h001, 12'h021, 12'h321};
    logic [4:0]  ot [12] = '{`OP_INC, `OP_ADD, `OP_ADC, `OP_SBC, `OP_SUB, `OP_DEC,
                             `OP_XOR, `OP_OR, `OP_SL1, `OP_SR0, `OP_AND, `OP_LDA};
    logic [4:0]  et [12] = '{5'h06, 5'h0b, 5'h10, 5'h15, 5'h10, 5'h14,
                             5'h11, 5'h15, 5'h1b, 5'h12, 5'h10, 5'h15};

    nibble_cpu_sequencer_core #(.SPLIT_N(4'h3)) i_dut (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .step_i(step_i), .xfer_i(xfer_i),
        .cond_i(cond_i), .operand_i(operand_i), .op_i(op_i), .indexed_i(indexed_i),
        .dir_addr_i(dir_addr_i), .wr_sel_i(wr_sel_i), .imm_i(imm_i), .irq_req_i(irq_req_i),
        .lut_data_i(lut_data_i), .pc_o(pc_o), .index_ptr_o(index_ptr_o),
        .stack_ptr_o(stack_ptr_o), .sum_o(sum_o), .carry_o(carry_o), .zero_o(zero_o),
        .lut_byte_o(lut_byte_o), .lut_valid_o(lut_valid_o), .disp_data_o(disp_data_o),
        .disp_strobe_o(disp_strobe_o), .irq_ack_o(irq_ack_o),
        .code_words_o(code_words_o), .lut_bytes_o(lut_bytes_o));

    lookup_store_model i_lut (.index_ptr_i(index_ptr_o), .lut_data_o(lut_data_i));
// ----------------------------------------
// clock, timeout, tasks
// ----------------------------------------
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // about 170 cycles needed, generous margin
    always @(posedge sys_clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt = error_cnt + 1;
            results;
        end
    end

    task results;
        if (error_cnt == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one step, then a gap cycle so step_i never toggles twice at once
    task exec(input logic [2:0] x, input logic [4:0] o, input logic [10:0] d,
              input logic [6:0] a, input logic [5:0] q);
        @(negedge sys_clk_i);
        xfer_i = x;
        op_i = o;
        operand_i = d;
        dir_addr_i = a;
        irq_req_i = q;
        step_i = 1'b1;
        @(negedge sys_clk_i);
        step_i = 1'b0;
        irq_req_i = 6'h00;
    endtask

    task long_jump(input logic [2:0] x, input logic [10:0] d);
        exec(x, `OP_NOP, d, 7'h00, 6'h00);
    endtask

    task op(input logic [4:0] o, input logic [6:0] a);
        exec(`XFER_NONE, o, 11'h000, a, 6'h00);
    endtask

    task alu(input logic [4:0] o, input logic [3:0] s, input logic c);
        op(o, 7'h00);
        chk(12'(sum_o), 12'(s));
        chk(12'(carry_o), 12'(c));
    endtask

    // ram is not reset, so a value is forced through the working register
    task put(input logic [3:0] v);
        imm_i = 4'h0;
        op(`OP_AND_WR_IMM, 7'h00);
        imm_i = v;
        op(`OP_ADD_WR_IMM, 7'h00);
    endtask

    task do_reset;
        @(negedge sys_clk_i);
        srst_i = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        srst_i = 1'b0;
    endtask
// ----------------------------------------
// tests
// ----------------------------------------
    initial
    begin
        do_reset;
        chk(12'(pc_o), 12'h000);
        chk(12'(stack_ptr_o), 12'h007);
        chk(code_words_o, 12'h980);
        chk(lut_bytes_o, 12'h500);
        long_jump(`XFER_NONE, 11'h7ff);
        chk(12'(pc_o), 12'h001);
        long_jump(`XFER_LONG_JUMP, 11'h5f0);
        chk(12'(pc_o), 12'h5f0);
        long_jump(`XFER_PAGE_JUMP, 11'h012);
        chk(12'(pc_o), 12'h412);
        long_jump(`XFER_CALL, 11'h123);
        chk(12'(stack_ptr_o), 12'h000);
        for (i = 1; i < 9; i = i + 1)
        begin
            long_jump(`XFER_CALL, 11'(11'h100 + i));
            chk(12'(pc_o), 12'(12'h100 + i));
            chk(12'(stack_ptr_o), 12'(i % 8));
        end
        long_jump(`XFER_RETURN, 11'h000);
        chk(12'(pc_o), 12'h108);
        chk(12'(stack_ptr_o), 12'h007);
        for (i = 7; i > 1; i = i - 1)
        begin
            long_jump(`XFER_RETURN, 11'h000);
            chk(12'(pc_o), 12'(12'h100 + i));
            chk(12'(stack_ptr_o), 12'(i - 1));
        end
        long_jump(`XFER_RETURN, 11'h000);
        chk(12'(pc_o), 12'h124);
        long_jump(`XFER_RETURN, 11'h000);
        chk(12'(pc_o), 12'h108);
        chk(12'(stack_ptr_o), 12'h007);
        // a jump offered with the request must not run
        for (i = 0; i < 7; i = i + 1)
        begin
            exec(`XFER_LONG_JUMP, `OP_NOP, 11'h3ff, 7'h00, qt[i]);
            chk(12'(pc_o), 12'(vt[i]));
            chk(12'(irq_ack_o), 12'h001);
            long_jump(`XFER_RETURN, 11'h000);
            chk(12'(pc_o), 12'h108);
        end

        do_reset;
        for (i = 0; i < 3; i = i + 1)
        begin
            put(4'(i + 1));
            op(`OP_STA, at[i]);
            op(pt[i], at[i]);
            chk(index_ptr_o, it[i]);
        end
        op(`OP_LUT_RD, 7'h00);
        chk(12'(lut_byte_o), 12'(8'h21 ^ 8'h33));
        chk(12'(lut_valid_o), 12'h001);
        // pointer 321h lies past the ram, so reads give zero
        indexed_i = 1'b1;
        op(`OP_LDA, 7'h00);
        chk(12'(sum_o), 12'h000);
        indexed_i = 1'b0;
        wr_sel_i = 4'h3;
        op(`OP_WR_DISP, 7'h00);
        chk(12'(disp_data_o), 12'h003);
        chk(12'(disp_strobe_o), 12'h001);
        op(`OP_MOV_RAM_WR, 7'h05);
        op(`OP_WR_DISP, 7'h00);
        chk(12'(disp_data_o), 12'h001);

        do_reset;
        put(4'h7);
        alu(`OP_DAA, 4'h7, 1'b0);
        alu(`OP_DAS, 4'h1, 1'b0);
        put(4'ha);
        alu(`OP_DAA, 4'h0, 1'b1);
        chk(12'(zero_o), 12'h001);
        alu(`OP_DAA, 4'h6, 1'b1);
        alu(`OP_DAA, 4'h6, 1'b1);
        alu(`OP_DAS, 4'h6, 1'b1);
        cond_i = `COND_CARRY;
        long_jump(`XFER_COND_JUMP, 11'h055);
        chk(12'(pc_o), 12'h055);
        // binary ops against working register 3, which holds 5
        put(4'h5);
        for (i = 0; i < 12; i = i + 1)
        begin
            op(ot[i], 7'h73);
            chk(12'({carry_o, sum_o}), 12'(et[i]));
        end
        results;
    end
endmodule // test_nibble_cpu_sequencer_core

// File: hdl/nibble_cpu_sequencer_core.v
// Overview of operation
// [R1] 11-bit program counter steps by one unless a transfer loads it.
// [R2] long_jump and call load the counter from low operand bits; the code loads all 11 operand bits.
// [R3] other jumps keep page_bit and take remaining bits from operand.
// [R4] reset forces the program counter to zero.
// [R5] vectors: external pin 010H, port C/D 014H, timer one 018H.
// [R6] vectors: pre-divider 01CH, timer two 020H, frequency counter 028H.
// [R7] calls and interrupt entries push the program counter on the stack.
// [R8] return loads counter from entry at stack pointer, then decrements it.
// [R9] stack is eight 11-bit entries with no overflow flag.
// [R10] push with stack full wraps pointer to level zero and overwrites.
// [R11] return with stack empty wraps pointer to seven, restores that entry.
// [R12] rom split by N: code 2048+128N words, lookup 256(8-N) bytes.
// [R13] lookup_store data is 8 bits wide, addressed by index_pointer.
// [R14] 12-bit index_pointer addresses data ram and whole lookup_store.
// [R15] pointer load ops copy addressed ram nibble into chosen nibble.
// [R16] 128 nibbles of ram reached directly at 00H to 7FH.
// [R17] indexed ram addresses come from index_pointer up to FFH; the code reaches only 00H to 7FH.
// [R18] ram 70H to 7FH double as working registers for immediate ops.
// [R19] move nibble between working register and ram, or to display.
// [R20] alu adds, subtracts, logic, shifts with fill, tests, decimal adjust.
// [R21] add adjust: carry clear 0-9 keep; A-F add 6 set carry; carry 0-3 add 6.
// [R22] sub adjust: carry set 0-9 keep; carry clear 6-F add A, carry kept.
// [R23] other decimal adjust inputs leave sum and carry unchanged.
`timescale 1ns/100ps
`include "nibble_seq_consts.vh"

module nibble_cpu_sequencer_core
#(
    parameter [3:0] SPLIT_N = 4'h0
)
(
    input  wire                 sys_clk_i,
    input  wire                 srst_i,
    input  wire                 step_i,
    input  wire [`XFER_W-1:0]   xfer_i,
    input  wire [`COND_W-1:0]   cond_i,
    input  wire [10:0]          operand_i,
    input  wire [`OP_W-1:0]     op_i,
    input  wire                 indexed_i,
    input  wire [`RAM_AW-1:0]   dir_addr_i,
    input  wire [3:0]           wr_sel_i,
    input  wire [3:0]           imm_i,
    input  wire [5:0]           irq_req_i,
    input  wire [7:0]           lut_data_i,
    output reg  [`PC_W-1:0]     pc_o,
    output reg  [`IDX_W-1:0]    index_ptr_o,
    output reg  [`SP_W-1:0]     stack_ptr_o,
    output reg  [3:0]           sum_o,
    output reg                  carry_o,
    output reg                  zero_o,
    output reg  [7:0]           lut_byte_o,
    output reg                  lut_valid_o,
    output reg  [3:0]           disp_data_o,
    output reg                  disp_strobe_o,
    output reg                  irq_ack_o,
    output reg  [11:0]          code_words_o,
    output reg  [11:0]          lut_bytes_o
);

// ----------------------------------------
// storage
// ----------------------------------------
// [R9] eight levels, no overflow flag
reg  [`PC_W-1:0]    stack_r [0:`STK_DEPTH-1];
// [R16] data ram of 128 nibbles
reg  [3:0]          ram_r   [0:`RAM_WORDS-1];

// ----------------------------------------
// functions
// ----------------------------------------
// [R5] [R6] interrupt vector lookup, lowest index wins
function [`PC_W-1:0] irq_vector;
    input [5:0] req;
    begin
        if (req[0])
            irq_vector = `VEC_EXT_PIN;
        else if (req[1])
            irq_vector = `VEC_PORT_CD;
        else if (req[2])
            irq_vector = `VEC_TIMER1;
        else if (req[3])
            irq_vector = `VEC_PREDIV;
        else if (req[4])
            irq_vector = `VEC_TIMER2;
        else
            irq_vector = `VEC_RFC;
    end
endfunction

// indexed addresses above 7FH have no ram behind them
function [`RAM_AW-1:0] ram_index;
    input [`IDX_W-1:0] ptr;
    begin
        ram_index = ptr[`RAM_AW-1:0];
    end
endfunction

// ----------------------------------------
// operand fetch
// ----------------------------------------
wire [`RAM_AW-1:0]  wr_addr;
wire [`RAM_AW-1:0]  opnd_addr;
wire                ptr_in_ram;
wire [3:0]          opnd_data;
wire [3:0]          wr_data;
wire                irq_take;

// [R18] working registers sit at 70H..7FH
assign wr_addr   = `WR_BASE | {3'h0, wr_sel_i};
// [R17] indexed reach only up to 7FH, not FFH
assign ptr_in_ram = (index_ptr_o[11:7] == 5'h00);
assign opnd_addr = indexed_i ? ram_index(index_ptr_o) : dir_addr_i;
assign opnd_data = (indexed_i && !ptr_in_ram) ? 4'h0 : ram_r[opnd_addr];
assign wr_data   = ram_r[wr_addr];
assign irq_take  = step_i && (irq_req_i != 6'h00);

// ----------------------------------------
// alu
// ----------------------------------------
reg  [3:0]  sum_nxt;
reg         carry_nxt;
reg  [3:0]  res_nxt;
reg         res_wr_nxt;
reg  [4:0]  wide;

// [R20] alu function set
always @*
begin
    sum_nxt    = sum_o;
    carry_nxt  = carry_o;
    res_nxt    = 4'h0;
    res_wr_nxt = 1'b0;
    wide       = 5'h00;
    case (op_i)
        `OP_ADD:
        begin
            wide      = {1'b0, sum_o} + {1'b0, opnd_data};
            sum_nxt   = wide[3:0];
            carry_nxt = wide[4];
        end
        `OP_ADC:
        begin
            wide      = {1'b0, sum_o} + {1'b0, opnd_data} + {4'h0, carry_o};
            sum_nxt   = wide[3:0];
            carry_nxt = wide[4];
        end
        // carry set means no borrow
        `OP_SUB:
        begin
            wide      = {1'b0, opnd_data} + {1'b0, ~sum_o} + 5'h01;
            sum_nxt   = wide[3:0];
            carry_nxt = wide[4];
        end
        `OP_SBC:
        begin
            wide      = {1'b0, opnd_data} + {1'b0, ~sum_o} + {4'h0, carry_o};
            sum_nxt   = wide[3:0];
            carry_nxt = wide[4];
        end
        `OP_INC:
        begin
            wide      = {1'b0, opnd_data} + 5'h01;
            sum_nxt   = wide[3:0];
            carry_nxt = wide[4];
        end
        `OP_DEC:
        begin
            wide      = {1'b0, opnd_data} + 5'h0f;
            sum_nxt   = wide[3:0];
            carry_nxt = wide[4];
        end
        `OP_AND:
            sum_nxt = sum_o & opnd_data;
        `OP_XOR:
            sum_nxt = sum_o ^ opnd_data;
        `OP_OR:
            sum_nxt = sum_o | opnd_data;
        `OP_SR0:
            sum_nxt = {1'b0, opnd_data[3:1]};
        `OP_SR1:
            sum_nxt = {1'b1, opnd_data[3:1]};
        `OP_SL0:
            sum_nxt = {opnd_data[2:0], 1'b0};
        `OP_SL1:
            sum_nxt = {opnd_data[2:0], 1'b1};
        // [R21] add adjust table
        `OP_DAA:
        begin
            if (!carry_o && sum_o >= 4'ha)
            begin
                sum_nxt   = sum_o + 4'h6;
                carry_nxt = 1'b1;
            end
            else if (carry_o && sum_o <= 4'h3)
                sum_nxt = sum_o + 4'h6;
            // [R23] other inputs untouched
            res_nxt    = sum_nxt;
            res_wr_nxt = 1'b1;
        end
        // [R22] sub adjust table
        `OP_DAS:
        begin
            if (!carry_o && sum_o >= 4'h6)
                sum_nxt = sum_o + 4'ha;
            // [R23] other inputs untouched
            res_nxt    = sum_nxt;
            res_wr_nxt = 1'b1;
        end
        `OP_LDA:
            sum_nxt = opnd_data;
        `OP_STA:
        begin
            res_nxt    = sum_o;
            res_wr_nxt = 1'b1;
        end
        default:
            sum_nxt = sum_o;
    endcase
end

// ----------------------------------------
// branch condition
// ----------------------------------------
reg cond_ok;

// [R20] bit and flag tests
always @*
begin
    case (cond_i)
        `COND_CARRY:
            cond_ok = carry_o;
        `COND_NCARRY:
            cond_ok = !carry_o;
        `COND_ZERO:
            cond_ok = zero_o;
        `COND_NZERO:
            cond_ok = !zero_o;
        default:
            cond_ok = sum_o[cond_i[1:0]];
    endcase
end

// ----------------------------------------
// sequencer
// ----------------------------------------
wire [`SP_W-1:0] sp_up;
wire [`SP_W-1:0] sp_down;
wire [4:0]       wr_imm_sum;

// [R10] [R11] three-bit pointer wraps naturally
assign sp_up      = stack_ptr_o + 3'h1;
assign sp_down    = stack_ptr_o - 3'h1;
assign wr_imm_sum = {1'b0, wr_data} + {1'b0, imm_i};

always @(posedge sys_clk_i)
begin
    if (srst_i)
    begin
        // [R4] start at reset vector
        pc_o          <= `PC_RESET;
        stack_ptr_o   <= `SP_RESET;
        index_ptr_o   <= `IDX_RESET;
        sum_o         <= 4'h0;
        carry_o       <= 1'b0;
        zero_o        <= 1'b0;
        lut_byte_o    <= 8'h00;
        lut_valid_o   <= 1'b0;
        disp_data_o   <= 4'h0;
        disp_strobe_o <= 1'b0;
        irq_ack_o     <= 1'b0;
    end
    else
    begin
        lut_valid_o   <= 1'b0;
        disp_strobe_o <= 1'b0;
        irq_ack_o     <= 1'b0;
        if (irq_take)
        begin
            // [R7] save return address on entry
            stack_r[sp_up] <= pc_o;
            stack_ptr_o    <= sp_up;
            pc_o           <= irq_vector(irq_req_i);
            irq_ack_o      <= 1'b1;
        end
        else if (step_i)
        begin
            sum_o   <= sum_nxt;
            carry_o <= carry_nxt;
            zero_o  <= (sum_nxt == 4'h0);
            if (res_wr_nxt && !(indexed_i && !ptr_in_ram))
                ram_r[opnd_addr] <= res_nxt;
            case (op_i)
                // [R15] pointer nibble loads
                `OP_PTR_LOW:
                    index_ptr_o[3:0] <= opnd_data;
                `OP_PTR_MID:
                    index_ptr_o[7:4] <= opnd_data;
                `OP_PTR_TOP:
                    index_ptr_o[11:8] <= opnd_data;
                // [R19] nibble moves and display
                `OP_MOV_WR_RAM:
                    ram_r[dir_addr_i] <= wr_data;
                `OP_MOV_RAM_WR:
                    ram_r[wr_addr] <= ram_r[dir_addr_i];
                `OP_WR_DISP:
                begin
                    disp_data_o   <= wr_data;
                    disp_strobe_o <= 1'b1;
                end
                // [R13] byte wide lookup read
                `OP_LUT_RD:
                begin
                    lut_byte_o  <= lut_data_i;
                    lut_valid_o <= 1'b1;
                end
                // [R18] immediate ops on working register
                `OP_ADD_WR_IMM:
                begin
                    ram_r[wr_addr] <= wr_imm_sum[3:0];
                    sum_o          <= wr_imm_sum[3:0];
                    carry_o        <= wr_imm_sum[4];
                end
                `OP_SUB_WR_IMM:
                begin
                    ram_r[wr_addr] <= wr_data - imm_i;
                    sum_o          <= wr_data - imm_i;
                    carry_o        <= (wr_data >= imm_i);
                end
                `OP_AND_WR_IMM:
                begin
                    ram_r[wr_addr] <= wr_data & imm_i;
                    sum_o          <= wr_data & imm_i;
                end
                `OP_XOR_WR_IMM:
                begin
                    ram_r[wr_addr] <= wr_data ^ imm_i;
                    sum_o          <= wr_data ^ imm_i;
                end
                `OP_OR_WR_IMM:
                begin
                    ram_r[wr_addr] <= wr_data | imm_i;
                    sum_o          <= wr_data | imm_i;
                end
                default:
                    index_ptr_o <= index_ptr_o;
            endcase
            case (xfer_i)
                // [R2] full operand load
                `XFER_LONG_JUMP:
                    pc_o <= operand_i;
                `XFER_CALL:
                begin
                    // [R7] [R10] push, wraps to zero when full
                    stack_r[sp_up] <= pc_o + 11'h001;
                    stack_ptr_o    <= sp_up;
                    pc_o           <= operand_i;
                end
                // [R3] keep page bit
                `XFER_PAGE_JUMP:
                    pc_o <= {pc_o[10], operand_i[9:0]};
                `XFER_COND_JUMP:
                    pc_o <= cond_ok ? {pc_o[10], operand_i[9:0]} : pc_o + 11'h001;
                // [R8] [R11] pop then decrement, wraps to seven
                `XFER_RETURN:
                begin
                    pc_o        <= stack_r[stack_ptr_o];
                    stack_ptr_o <= sp_down;
                end
                // [R1] plain increment
                default:
                    pc_o <= pc_o + 11'h001;
            endcase
        end
    end
end

// ----------------------------------------
// rom partition
// ----------------------------------------
wire [3:0] split_n;

// out-of-range split clamps to all code
assign split_n = (SPLIT_N > `SPLIT_N_MAX) ? `SPLIT_N_MAX : SPLIT_N;

// [R12] [R14] partition sizes
always @(posedge sys_clk_i)
begin
    code_words_o <= `CODE_BASE_WORDS + ({8'h00, split_n} * `CODE_STEP_WORDS);
    lut_bytes_o  <= ({8'h00, `SPLIT_N_MAX - split_n} * `LUT_STEP_BYTES);
end

endmodule // nibble_cpu_sequencer_core

// File: hdl/nibble_seq_consts.vh
`ifndef NIBBLE_SEQ_CONSTS_VH
`define NIBBLE_SEQ_CONSTS_VH
// ----------------------------------------
// program counter and vectors
// ----------------------------------------
`define PC_W            11
`define PC_RESET        11'h000
`define VEC_EXT_PIN     11'h010
`define VEC_PORT_CD     11'h014
`define VEC_TIMER1      11'h018
`define VEC_PREDIV      11'h01c
`define VEC_TIMER2      11'h020
`define VEC_RFC         11'h028
// ----------------------------------------
// stack
// ----------------------------------------
`define STK_DEPTH       8
`define SP_W            3
`define SP_RESET        3'h7
`define SP_WRAP_PUSH    3'h0
`define SP_WRAP_POP     3'h7
// ----------------------------------------
// rom partition
// ----------------------------------------
`define ROM_WORDS       12'hc00
`define CODE_BASE_WORDS 12'h800
`define CODE_STEP_WORDS 12'h080
`define LUT_STEP_BYTES  12'h100
`define SPLIT_N_MAX     4'h8
// ----------------------------------------
// index pointer and ram
// ----------------------------------------
`define IDX_W           12
`define IDX_RESET       12'h000
`define RAM_WORDS       128
`define RAM_AW          7
`define WR_BASE         7'h70
// ----------------------------------------
// operation codes
// ----------------------------------------
`define OP_W            5
`define OP_NOP          5'h00
`define OP_ADD          5'h01
`define OP_ADC          5'h02
`define OP_SUB          5'h03
`define OP_SBC          5'h04
`define OP_INC          5'h05
`define OP_DEC          5'h06
`define OP_AND          5'h07
`define OP_XOR          5'h08
`define OP_OR           5'h09
`define OP_SR0          5'h0a
`define OP_SR1          5'h0b
`define OP_SL0          5'h0c
`define OP_SL1          5'h0d
`define OP_DAA          5'h0e
`define OP_DAS          5'h0f
`define OP_LDA          5'h10
`define OP_STA          5'h11
`define OP_PTR_LOW      5'h12
`define OP_PTR_MID      5'h13
`define OP_PTR_TOP      5'h14
`define OP_MOV_WR_RAM   5'h15
`define OP_MOV_RAM_WR   5'h16
`define OP_WR_DISP      5'h17
`define OP_LUT_RD       5'h18
`define OP_ADD_WR_IMM   5'h19
`define OP_AND_WR_IMM   5'h1a
`define OP_XOR_WR_IMM   5'h1b
`define OP_OR_WR_IMM    5'h1c
`define OP_SUB_WR_IMM   5'h1d
// ----------------------------------------
// control transfer codes
// ----------------------------------------
`define XFER_W          3
`define XFER_NONE       3'h0
`define XFER_LONG_JUMP  3'h1
`define XFER_CALL       3'h2
`define XFER_PAGE_JUMP  3'h3
`define XFER_RETURN     3'h4
`define XFER_COND_JUMP  3'h5
// ----------------------------------------
// condition select for branches
// ----------------------------------------
`define COND_W          3
`define COND_CARRY      3'h4
`define COND_NCARRY     3'h5
`define COND_ZERO       3'h6
`define COND_NZERO      3'h7
`endif
